// [logic/deep_halt_consts.vh]
`ifndef DEEP_HALT_CONSTS_VH
`define DEEP_HALT_CONSTS_VH
`define SYSCTL1_OFS 8'h38
`define STATUS_OFS 8'h3A
`define MASK_OFS 8'h3B
`define SYSCTL1_RST 8'h00
`define BIT_HALT 7
`define BIT_METHOD 6
`define BIT_TARGET 5
`define BIT_HOLD 4
`define WUT_HI 3
`define WUT_LO 2
`define WU_FAST_00 24'h030000
`define WU_FAST_01 24'h010000
`define WU_FAST_10 24'h00C000
`define WU_FAST_11 24'h004000
`define WU_SLOW_00 24'h006000
`define WU_SLOW_01 24'h002000
`define WU_SLOW_10 24'h0000C0
`define WU_SLOW_11 24'h000040
`endif

// [logic/warmup_counter.v]
`timescale 1ns/1ps
`include "deep_halt_consts.vh"
module warmup_counter #(
  parameter WIDTH = 24
) (
  input wire ref_clk,
  input wire reset,
  input wire start,
  input wire oscTick,
  input wire slowSel,
  input wire [1:0] warmupSel,
  output reg done
);
  reg [WIDTH-1:0] count_r;
  reg [WIDTH-1:0] limit;
  reg running_r;
  always @* begin
    case ({slowSel, warmupSel})
      3'h0: limit = `WU_FAST_00;
      3'h1: limit = `WU_FAST_01;
      3'h2: limit = `WU_FAST_10;
      3'h3: limit = `WU_FAST_11;
      3'h4: limit = `WU_SLOW_00;
      3'h5: limit = `WU_SLOW_01;
      3'h6: limit = `WU_SLOW_10;
      default: limit = `WU_SLOW_11;
    endcase
  end
  always @(posedge ref_clk) begin
    if (reset) begin
      count_r <= {WIDTH{1'b0}};
      running_r <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count_r <= {WIDTH{1'b0}};
        running_r <= 1'b1;
      end else if (running_r && oscTick) begin
        if (count_r == limit - 1'b1) begin
          running_r <= 1'b0;
          done <= 1'b1;
        end
        count_r <= count_r + 1'b1;
      end
    end
  end
endmodule

// [logic/deep_halt_mode_control.v]
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "deep_halt_consts.vh"
module deep_halt_mode_control (
  input wire ref_clk,
  input wire reset,
  input wire [7:0] addr,
  input wire [7:0] wrData,
  input wire wrStrobe,
  input wire rdStrobe,
  output reg [7:0] rdData,
  input wire wakePinIn,
  input wire [7:0] portIn,
  input wire [7:0] portOutLatch,
  input wire fastOscTick,
  input wire slowOscTick,
  input wire slowRunning,
  output reg wakePinOe,
  output reg [7:0] portOut,
  output reg [7:0] portOe,
  output reg [7:0] portInToCore,
  output reg coreHalt,
  output reg fastOscEn,
  output reg slowOscEn,
  output reg slowRunSel,
  output reg prescalerClear,
  output reg irq
);
  localparam ST_RUN = 2'h0;
  localparam ST_HALT = 2'h1;
  localparam ST_WARM = 2'h2;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg haltBit_r;
  reg methodLevel_r;
  reg targetSlow_r;
  reg pinHold_r;
  reg [1:0] warmupSel_r;
  reg [2:0] status_r;
  reg [2:0] mask_r;
  reg wakeSync1_r;
  reg wakeSync2_r;
  reg wakePrev_r;
  reg warmSlow_r;
  reg [7:0] portIn1_r;
  reg [7:0] portIn2_r;
  wire warmDone;
  wire wakeRise;
  wire wakeHit;
  wire enterReq;
  wire ctlWrite;
  wire startWarm;
  wire releaseSlow;
  wire holdNow;
  reg [2:0] events;
  integer i;

  assign ctlWrite = wrStrobe && addr == `SYSCTL1_OFS;
  assign enterReq = ctlWrite && wrData[`BIT_HALT] && state_r == ST_RUN;
  assign wakeRise = wakeSync2_r && !wakePrev_r;
  assign wakeHit = methodLevel_r ? wakeSync2_r : wakeRise;
  // in level method, an already-high pin goes straight to warm-up
  assign startWarm = (state_r == ST_HALT && wakeHit) ||
    (enterReq && wrData[`BIT_METHOD] && wakeSync2_r);
  assign releaseSlow = enterReq ? wrData[`BIT_TARGET] : targetSlow_r;
  // pin-hold of the entering write, not the stale one
  assign holdNow = enterReq ? wrData[`BIT_HOLD] : pinHold_r;

  warmup_counter #(
    .WIDTH(24)
  ) u_warm (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(startWarm),
    .oscTick(warmSlow_r ? slowOscTick : fastOscTick),
    .slowSel(warmSlow_r),
    .warmupSel(warmupSel_r),
    .done(warmDone)
  );

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (startWarm)
          state_nxt = ST_WARM;
        else if (enterReq)
          state_nxt = ST_HALT;
      end
      ST_HALT: begin
        if (startWarm)
          state_nxt = ST_WARM;
      end
      ST_WARM: begin
        if (warmDone)
          state_nxt = ST_RUN;
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  always @* begin
    events = 3'h0;
    events[0] = state_r == ST_RUN && state_nxt != ST_RUN;
    events[1] = startWarm;
    events[2] = state_r == ST_WARM && warmDone;
  end

  // two-stage sync for outside pins
  always @(posedge ref_clk) begin
    if (reset) begin
      wakeSync1_r <= 1'b0;
      wakeSync2_r <= 1'b0;
      wakePrev_r <= 1'b0;
      portIn1_r <= 8'h00;
      portIn2_r <= 8'h00;
    end else begin
      wakeSync1_r <= wakePinIn;
      wakeSync2_r <= wakeSync1_r;
      wakePrev_r <= wakeSync2_r;
      portIn1_r <= portIn;
      portIn2_r <= portIn1_r;
    end
  end

  always @(posedge ref_clk) begin
    if (reset) begin
      // reset returns to fast single run
      state_r <= ST_RUN;
      haltBit_r <= 1'b0;
      methodLevel_r <= 1'b0;
      targetSlow_r <= 1'b0;
      pinHold_r <= 1'b0;
      warmupSel_r <= 2'h0;
      warmSlow_r <= 1'b0;
      status_r <= 3'h0;
      mask_r <= 3'h0;
      rdData <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (ctlWrite && state_r == ST_RUN) begin
        haltBit_r <= wrData[`BIT_HALT];
        methodLevel_r <= wrData[`BIT_METHOD];
        targetSlow_r <= wrData[`BIT_TARGET];
        pinHold_r <= wrData[`BIT_HOLD];
        warmupSel_r <= wrData[`WUT_HI:`WUT_LO];
      end
      if (enterReq)
        warmSlow_r <= wrData[`BIT_TARGET];
      if (state_r == ST_WARM && warmDone)
        haltBit_r <= 1'b0;
      if (wrStrobe && addr == `MASK_OFS)
        mask_r <= wrData[2:0];
      // set wins over write-one clear
      status_r <= (status_r & ~((wrStrobe && addr == `STATUS_OFS) ? wrData[2:0] : 3'h0)) | events;
      rdData <= 8'h00;
      if (rdStrobe) begin
        case (addr)
          // low bits not driven, read zero
          `SYSCTL1_OFS: rdData <= {haltBit_r, methodLevel_r, targetSlow_r, pinHold_r, warmupSel_r, 2'h0};
          `STATUS_OFS: rdData <= {5'h00, status_r};
          `MASK_OFS: rdData <= {5'h00, mask_r};
          default: rdData <= 8'h00;
        endcase
      end
    end
  end

  // registered outputs
  always @(posedge ref_clk) begin
    if (reset) begin
      coreHalt <= 1'b0;
      fastOscEn <= 1'b1;
      slowOscEn <= 1'b0;
      slowRunSel <= 1'b0;
      prescalerClear <= 1'b0;
      wakePinOe <= 1'b0;
      portOut <= 8'h00;
      portOe <= 8'h00;
      portInToCore <= 8'h00;
      irq <= 1'b0;
    end else begin
      // core held through halt and warm-up
      coreHalt <= state_nxt != ST_RUN;
      fastOscEn <= state_nxt == ST_RUN ? !slowRunSel || slowRunning :
        (state_nxt == ST_WARM && !releaseSlow);
      slowOscEn <= state_nxt == ST_RUN ? slowRunning : (state_nxt == ST_WARM && (releaseSlow || slowRunning));
      if (state_r == ST_WARM && warmDone)
        slowRunSel <= warmSlow_r;
      prescalerClear <= state_nxt != ST_RUN;
      wakePinOe <= 1'b0;
      portOut <= portOutLatch;
      for (i = 0; i < 8; i = i + 1) begin
        portOe[i] <= (state_nxt == ST_RUN) || holdNow;
        portInToCore[i] <= (state_nxt != ST_RUN && !holdNow) ? 1'b0 : portIn2_r[i];
      end
      irq <= |(status_r & mask_r);
    end
  end
endmodule

// [testbench/dhm_chk_asserts.sv]
`timescale 1ns/1ps
module dhm_chk (
  input wire ref_clk,
  input wire reset,
  input wire [7:0] addr,
  input wire [7:0] wrData,
  input wire wrStrobe,
  input wire rdStrobe,
  input wire [7:0] rdData,
  input wire wakePinOe,
  input wire [7:0] portOe,
  input wire [7:0] portInToCore,
  input wire coreHalt,
  input wire fastOscEn,
  input wire slowRunSel,
  input wire prescalerClear,
  input wire irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_pin; !wakePinOe; endproperty
  a_pin: assert property (p_pin) else $error("wake pin driven");
  // reset itself is the cause here, so it may not disable the check
  property p_rst; disable iff (1'b0) reset |=> !coreHalt && fastOscEn && !slowRunSel; endproperty
  a_rst: assert property (p_rst) else $error("reset not fast run");
  property p_oe; !$past(reset) && !$past(coreHalt) && !coreHalt |-> portOe == 8'hFF; endproperty
  a_oe: assert property (p_oe) else $error("port not driven in run");
  property p_in; $past(coreHalt) && coreHalt && portOe == 8'h00 |-> portInToCore == 8'h00; endproperty
  a_in: assert property (p_in) else $error("inputs not forced low");
  property p_wr; wrStrobe && addr == 8'h38 && wrData[7] && !coreHalt |=> coreHalt; endproperty
  a_wr: assert property (p_wr) else $error("halt not entered");
  property p_rd; rdStrobe && addr == 8'h38 |=> rdData[1:0] == 2'b00; endproperty
  a_rd: assert property (p_rd) else $error("low bits not zero");
  property p_clr; prescalerClear == coreHalt; endproperty
  a_clr: assert property (p_clr) else $error("prescaler clear mismatch");
  property p_hold; $rose(coreHalt) |=> coreHalt[*8]; endproperty
  a_hold: assert property (p_hold) else $error("warm-up cut short");
  c_enter: cover property ($rose(coreHalt));
  c_leave: cover property ($fell(coreHalt));
  c_irq: cover property ($rose(irq));
endmodule
bind deep_halt_mode_control dhm_chk u_chk (.*);

// [testbench/wake_source.sv]
`timescale 1ns/1ps
module wake_source (
  input wire ref_clk,
  input wire fire,
  input wire [15:0] len,
  output logic wakePin
);
  logic [15:0] cnt_r = 16'h0000;
  // one rising edge, held len cycles
  always @(posedge ref_clk) begin
    if (fire) begin
      cnt_r <= len;
    end else if (cnt_r != 16'h0000) begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end
  assign wakePin = cnt_r != 16'h0000;
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic wrStrobe = 1'b0, rdStrobe = 1'b0, slowRunning = 1'b0, fire = 1'b0;
  logic fastOscTick = 1'b1, slowOscTick = 1'b1;
  logic [7:0] addr = 8'h00, wrData = 8'h00, portIn = 8'hA5, portOutLatch = 8'h3C, d;
  logic [7:0] rdData, portOut, portOe, portInToCore;
  logic wakePinIn, wakePinOe, coreHalt, fastOscEn, slowOscEn, slowRunSel, prescalerClear, irq;
  logic [15:0] len = 16'h0000;
  int num_errors = 0, n_checks = 0, cyc = 0, c, i;
  // control byte and its warm-up length at one tick per cycle
  logic [7:0] ctl [4] = '{8'hBC, 8'hA8, 8'hB4, 8'h8C};
  int wu [4] = '{64, 192, 8192, 16384};
  deep_halt_mode_control DUT (.*);
  wake_source src (.ref_clk(ref_clk), .fire(fire), .len(len), .wakePin(wakePinIn));
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (++cyc == 60000) begin
    num_errors++;
    end_of_test();
  end
  task chk(input string n, input [23:0] e, g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input [7:0] a, v);
    @(posedge ref_clk);
    addr <= a;
    wrData <= v;
    wrStrobe <= 1'b1;
    @(posedge ref_clk);
    wrStrobe <= 1'b0;
    #1;
  endtask
  task rd(input [7:0] a);
    @(posedge ref_clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge ref_clk);
    rdStrobe <= 1'b0;
    #1 d = rdData;
  endtask
  task wake(input [15:0] n);
    @(posedge ref_clk);
    fire <= 1'b1;
    len <= n;
    @(posedge ref_clk);
    fire <= 1'b0;
    #1;
  endtask
  // bounded wait, a stuck halt must not hang the run
  task waitRel;
    c = 0;
    while (coreHalt !== 1'b0 && c < 20000) begin
      @(posedge ref_clk);
      #1;
      c++;
    end
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    wr(8'h3B, 8'h01);
    for (i = 0; i < 4; i++) begin
      slowRunning <= ctl[i][5];
      wr(8'h38, ctl[i]);
      chk("halt", 1, coreHalt);
      chk("portOe", ctl[i][4] ? 8'hFF : 8'h00, portOe);
      chk("inCore", ctl[i][4] ? 8'hA5 : 8'h00, portInToCore);
      chk("pinOe", 0, wakePinOe);
      chk("fastOsc", 0, fastOscEn);
      chk("slowOsc", 0, slowOscEn);
      chk("portOut", 8'h3C, portOut);
      wake(16'h0010);
      chk("irq", 1, irq);
      waitRel();
      chk("warmup", 1, c >= wu[i] - 2 && c <= wu[i] + 10);
      chk("target", ctl[i][5], slowRunSel);
      wr(8'h3A, 8'h07);
      rd(8'h38);
      chk("ctl", {1'b0, ctl[i][6:2], 2'b00}, d);
      chk("irqClr", 0, irq);
    end
    slowRunning <= 1'b1;
    wake(16'h00C8);
    repeat (4) @(posedge ref_clk);
    wr(8'h38, 8'hFC);
    waitRel();
    chk("levelRel", 1, c < 100);
    wake(16'h012C);
    repeat (4) @(posedge ref_clk);
    wr(8'h38, 8'hBC);
    repeat (300) @(posedge ref_clk);
    chk("edgeHold", 1, coreHalt);
    wake(16'h0010);
    waitRel();
    chk("edgeRel", 0, coreHalt);
    wr(8'h38, 8'hBC);
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    chk("rstHalt", 0, coreHalt);
    chk("rstTarget", 0, slowRunSel);
    rd(8'h38);
    chk("rstCtl", 8'h00, d);
    rd(8'h10);
    chk("unmapped", 8'h00, d);
    wr(8'h38, 8'hBC);
    wake(16'h0010);
    waitRel();
    chk("masked", 0, irq);
    wr(8'h3B, 8'h01);
    rd(8'h3A);
    chk("status", 8'h07, d);
    chk("irqOn", 1, irq);
    end_of_test();
  end
endmodule
